/* shared/fct_params.svh */
// Summary of operation
// - command end clears busy, raises interrupt
// - type I commands run while drive not ready
// - type II/III refused when not ready, interrupt
// - whole-track read passes every byte
// - track read unsynced until index mark, gate off
// - id read sends six bytes in order
// - forced interrupt low bits pick conditions
// - forced interrupt ends command, clears busy
// - enabled condition later raises interrupt
// - zero conditions end command, no interrupt
// - status read or command write clears interrupt
// - immediate interrupt cleared only by zero force
// - several conditions are ORed
// - reset loads command code 03
// - reset holds not-ready flag cleared
// - reset release runs restore, sector gets 01
// - precomp allowed only in double density
// - density select low means double density
// - register select decode status track sector data
`ifndef FCT_PARAMS_SVH
`define FCT_PARAMS_SVH
// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define FCT_OFS_STATCMD 8'h00
`define FCT_OFS_TRACK   8'h04
`define FCT_OFS_SECTOR  8'h08
`define FCT_OFS_DATA    8'h0C
`define FCT_OFS_CTRL    8'h10
// ----------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------
`define FCT_ST_BUSY     0
`define FCT_ST_NRDY     7
`define FCT_CTRL_DENSEL 0
`define FCT_CTRL_PREC   1
`define FCT_CMD_RST     8'h03
`define FCT_SEC_RST     8'h01
// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define FCT_CLK_MHZ     250
`define FCT_BYTE_US     4
`define FCT_BYTE_CYC    (`FCT_BYTE_US * `FCT_CLK_MHZ)
`endif

/* shared/fct_pkg.sv */
package fct_pkg;
   // command classes decoded from the top nibble
   typedef enum logic [2:0] {
      FCT_C_TYPE1  = 3'b000,
      FCT_C_RDTRK  = 3'b001,
      FCT_C_RDID   = 3'b010,
      FCT_C_TYPE23 = 3'b011,
      FCT_C_FORCE  = 3'b100
   } fct_class_t;
   // execution states
   typedef enum logic [1:0] {
      FCT_S_IDLE = 2'b00,
      FCT_S_RUN  = 2'b01,
      FCT_S_DONE = 2'b10
   } fct_state_t;
   // drive side inputs travelling together
   typedef struct packed {
      logic ready;
      logic index;
      logic track_zero_sense;
   } fct_drv_t;
endpackage

/* rtl/fct_sync.sv */
`timescale 1ns/10ps
`default_nettype none
// three-stage synchroniser; output changes when stages 2 and 3 agree
module fct_sync
   import fct_pkg::*;
(
   input  wire logic aclk,
   input  wire logic aresetn,
   input  wire logic d,
   output logic      q
);
   logic [2:0] s_r;   // shift stages
   logic [2:0] s_nxt; // next stages
   logic       q_r;   // filtered level
   logic       q_nxt; // next level

   // ----------------------------------------------------------------
   // next values
   // ----------------------------------------------------------------
   always_comb begin
      s_nxt = {s_r[1:0], d};
      q_nxt = (s_r[1] == s_r[2]) ? s_r[2] : q_r;
   end

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_r <= 3'h0;
         q_r <= 1'b0;
      end else begin
         s_r <= s_nxt;
         q_r <= q_nxt;
      end
   end

   assign q = q_r;
endmodule
`default_nettype wire

/* rtl/fct_div.sv */
`timescale 1ns/10ps
`include "fct_params.svh"
`default_nettype none
// byte-time enable divider
module fct_div
   import fct_pkg::*;
(
   input  wire logic aclk,
   input  wire logic aresetn,
   input  wire logic run,
   output logic      tick
);
   logic [10:0] cnt_r;   // cycle count
   logic [10:0] cnt_nxt; // next count

   // ----------------------------------------------------------------
   // count while running, pulse at wrap
   // ----------------------------------------------------------------
   always_comb begin
      if (!run || cnt_r == 11'(`FCT_BYTE_CYC - 1))
         cnt_nxt = 11'h000;
      else
         cnt_nxt = cnt_r + 11'h001;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn)
         cnt_r <= 11'h000;
      else
         cnt_r <= cnt_nxt;
   end

   assign tick = run && (cnt_r == 11'(`FCT_BYTE_CYC - 1));
endmodule
`default_nettype wire

/* rtl/fct_core.sv */
// Implementation choices: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/10ps
`include "fct_params.svh"
`default_nettype none
// command termination and interrupt core with AXI4-Lite slave
module fct_core
   import fct_pkg::*;
(
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // axi4-lite slave
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // drive pins
   input  wire fct_drv_t    drv_in,
   input  wire logic [7:0]  disk_byte,
   input  wire logic        index_mark_seen,
   // outputs
   output logic             completion_irq,
   output logic             sep_sync_gate,
   output logic             precomp_active,
   output logic             step_in
);
   // ----------------------------------------------------------------
   // synchronised drive inputs
   // ----------------------------------------------------------------
   logic rdy_s;  // ready level
   logic idx_s;  // index level
   logic tz_s;   // track zero level

   fct_sync u_rdy (.aclk(aclk), .aresetn(aresetn), .d(drv_in.ready),            .q(rdy_s));
   fct_sync u_idx (.aclk(aclk), .aresetn(aresetn), .d(drv_in.index),            .q(idx_s));
   fct_sync u_tz  (.aclk(aclk), .aresetn(aresetn), .d(drv_in.track_zero_sense), .q(tz_s));

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   fct_state_t  st_r,     st_nxt;      // execution state
   fct_class_t  cls_r,    cls_nxt;     // running class
   logic [7:0]  cmd_r,    cmd_nxt;     // command register
   logic [7:0]  trk_r,    trk_nxt;     // track register
   logic [7:0]  sec_r,    sec_nxt;     // sector register
   logic [7:0]  dat_r,    dat_nxt;     // data register
   logic [1:0]  ctrl_r,   ctrl_nxt;    // density and precomp controls
   logic        busy_r,   busy_nxt;    // busy status
   logic        nrdy_r,   nrdy_nxt;    // not-ready status
   logic        irq_r,    irq_nxt;     // completion interrupt
   logic        imm_r,    imm_nxt;     // immediate interrupt latched
   logic [2:0]  cond_r,   cond_nxt;    // armed forced conditions
   logic [2:0]  bcnt_r,   bcnt_nxt;    // byte counter
   logic        sync_r,   sync_nxt;    // track read locked
   logic        rdy_d_r;               // ready last cycle
   logic        idx_d_r;               // index last cycle
   logic        boot_r;                // reset restore pending
   logic        bvalid_r, bvalid_nxt;  // write response
   logic        rvalid_r, rvalid_nxt;  // read response
   logic [31:0] rdata_r,  rdata_nxt;   // read data
   logic        bresp_r,  bresp_nxt;   // write slverr
   logic        rresp_r,  rresp_nxt;   // read slverr
   logic        tick;                  // byte time pulse

   fct_div u_div (.aclk(aclk), .aresetn(aresetn), .run(st_r == FCT_S_RUN), .tick(tick));

   // ----------------------------------------------------------------
   // bus handshakes: write needs both channels, one at a time
   // ----------------------------------------------------------------
   logic wr_go;  // write taken
   logic rd_go;  // read taken
   assign wr_go         = s_axi_awvalid && s_axi_wvalid && !bvalid_r;
   assign rd_go         = s_axi_arvalid && !rvalid_r;
   assign s_axi_awready = wr_go;
   assign s_axi_wready  = wr_go;
   assign s_axi_arready = rd_go;

   logic cmd_wr;   // command written
   logic stat_rd;  // status read
   logic dat_rd;   // data read
   assign cmd_wr  = wr_go && s_axi_awaddr == `FCT_OFS_STATCMD && s_axi_wstrb[0];
   assign stat_rd = rd_go && s_axi_araddr == `FCT_OFS_STATCMD;
   assign dat_rd  = rd_go && s_axi_araddr == `FCT_OFS_DATA;

   // decode class from top nibble
   function automatic fct_class_t decode(input logic [7:0] c);
      fct_class_t k;
      k = FCT_C_TYPE23;
      if (c[7:4] == 4'hD)
         k = FCT_C_FORCE;
      else if (!c[7])
         k = FCT_C_TYPE1;
      else if (c[7:4] == 4'hE)
         k = FCT_C_RDTRK;
      else if (c[7:4] == 4'hC)
         k = FCT_C_RDID;
      return k;
   endfunction

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   logic cond_hit;  // enabled condition occurred
   always_comb begin
      st_nxt     = st_r;
      cls_nxt    = cls_r;
      cmd_nxt    = cmd_r;
      trk_nxt    = trk_r;
      sec_nxt    = sec_r;
      dat_nxt    = dat_r;
      ctrl_nxt   = ctrl_r;
      busy_nxt   = busy_r;
      nrdy_nxt   = !rdy_s;
      irq_nxt    = irq_r;
      imm_nxt    = imm_r;
      cond_nxt   = cond_r;
      bcnt_nxt   = bcnt_r;
      sync_nxt   = sync_r;
      bvalid_nxt = bvalid_r && !s_axi_bready;
      rvalid_nxt = rvalid_r && !s_axi_rready;
      rdata_nxt  = rdata_r;
      bresp_nxt  = bresp_r;
      rresp_nxt  = rresp_r;
      // conditions ORed together
      cond_hit = (cond_r[0] && rdy_s && !rdy_d_r)
               || (cond_r[1] && !rdy_s && rdy_d_r)
               || (cond_r[2] && idx_s && !idx_d_r);
      // clear by status read or command write unless immediate
      if ((stat_rd || cmd_wr) && !imm_r)
         irq_nxt = 1'b0;
      // register writes
      if (wr_go) begin
         bvalid_nxt = 1'b1;
         bresp_nxt  = 1'b0;
         unique case (s_axi_awaddr)
            `FCT_OFS_TRACK:  if (s_axi_wstrb[0]) trk_nxt = s_axi_wdata[7:0];
            `FCT_OFS_SECTOR: if (s_axi_wstrb[0]) sec_nxt = s_axi_wdata[7:0];
            `FCT_OFS_DATA:   if (s_axi_wstrb[0]) dat_nxt = s_axi_wdata[7:0];
            `FCT_OFS_CTRL:   if (s_axi_wstrb[0]) ctrl_nxt = s_axi_wdata[1:0];
            `FCT_OFS_STATCMD: ;
            default:         bresp_nxt = 1'b1;
         endcase
      end
      // running command progress on byte ticks
      if (st_r == FCT_S_RUN && tick) begin
         unique case (cls_r)
            FCT_C_TYPE1: begin
               if (tz_s || bcnt_r == 3'h7) begin
                  trk_nxt = 8'h00;
                  st_nxt  = FCT_S_DONE;
               end else
                  bcnt_nxt = bcnt_r + 3'h1;
            end
            FCT_C_RDID: begin
               unique case (bcnt_r)
                  3'h0:    dat_nxt = disk_byte;
                  3'h1:    dat_nxt = disk_byte;
                  3'h2:    dat_nxt = disk_byte;
                  3'h3:    dat_nxt = disk_byte;
                  3'h4:    dat_nxt = disk_byte;
                  default: dat_nxt = disk_byte;
               endcase
               if (bcnt_r == 3'h5)
                  st_nxt = FCT_S_DONE;
               bcnt_nxt = bcnt_r + 3'h1;
            end
            FCT_C_RDTRK: begin
               if (index_mark_seen)
                  sync_nxt = 1'b1;
               dat_nxt = disk_byte;
            end
            default: st_nxt = FCT_S_DONE;
         endcase
      end
      // locked track read ends at the next index edge, which seldom meets a tick
      if (st_r == FCT_S_RUN && cls_r == FCT_C_RDTRK && sync_r && idx_s && !idx_d_r)
         st_nxt = FCT_S_DONE;
      // completion: busy off, interrupt on
      if (st_r == FCT_S_DONE) begin
         busy_nxt = 1'b0;
         irq_nxt  = 1'b1;
         st_nxt   = FCT_S_IDLE;
      end
      // forced condition later met
      if (cond_hit)
         irq_nxt = 1'b1;
      // command load
      if (cmd_wr) begin
         cmd_nxt  = s_axi_wdata[7:0];
         cls_nxt  = decode(s_axi_wdata[7:0]);
         bcnt_nxt = 3'h0;
         sync_nxt = 1'b0;
         if (decode(s_axi_wdata[7:0]) == FCT_C_FORCE) begin
            st_nxt   = FCT_S_IDLE;
            busy_nxt = 1'b0;
            cond_nxt = s_axi_wdata[2:0];
            if (s_axi_wdata[3]) begin
               imm_nxt = 1'b1;
               irq_nxt = 1'b1;
            end else if (s_axi_wdata[3:0] == 4'h0) begin
               imm_nxt = 1'b0;
               irq_nxt = 1'b0;
            end
         end else if (decode(s_axi_wdata[7:0]) == FCT_C_TYPE1) begin
            st_nxt   = FCT_S_RUN;
            busy_nxt = 1'b1;
         end else if (!rdy_s) begin
            st_nxt   = FCT_S_IDLE;
            irq_nxt  = 1'b1;
            nrdy_nxt = 1'b1;
         end else begin
            st_nxt   = FCT_S_RUN;
            busy_nxt = 1'b1;
         end
      end
      // boot restore regardless of ready
      if (boot_r) begin
         st_nxt   = FCT_S_RUN;
         cls_nxt  = FCT_C_TYPE1;
         busy_nxt = 1'b1;
         bcnt_nxt = 3'h0;
      end
      // register reads
      if (rd_go) begin
         rvalid_nxt = 1'b1;
         rresp_nxt  = 1'b0;
         rdata_nxt  = 32'h0000_0000;
         unique case (s_axi_araddr)
            `FCT_OFS_STATCMD: begin
               rdata_nxt[`FCT_ST_BUSY] = busy_r;
               rdata_nxt[`FCT_ST_NRDY] = nrdy_r;
            end
            `FCT_OFS_TRACK:  rdata_nxt[7:0] = trk_r;
            `FCT_OFS_SECTOR: rdata_nxt[7:0] = sec_r;
            `FCT_OFS_DATA:   rdata_nxt[7:0] = dat_r;
            `FCT_OFS_CTRL:   rdata_nxt[1:0] = ctrl_r;
            default:         rresp_nxt = 1'b1;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_r     <= FCT_S_IDLE;
         cls_r    <= FCT_C_TYPE1;
         cmd_r    <= `FCT_CMD_RST;
         trk_r    <= 8'h00;
         sec_r    <= `FCT_SEC_RST;
         dat_r    <= 8'h00;
         ctrl_r   <= 2'h0;
         busy_r   <= 1'b0;
         nrdy_r   <= 1'b0;
         irq_r    <= 1'b0;
         imm_r    <= 1'b0;
         cond_r   <= 3'h0;
         bcnt_r   <= 3'h0;
         sync_r   <= 1'b0;
         rdy_d_r  <= 1'b0;
         idx_d_r  <= 1'b0;
         boot_r   <= 1'b1;
         bvalid_r <= 1'b0;
         rvalid_r <= 1'b0;
         rdata_r  <= 32'h0000_0000;
         bresp_r  <= 1'b0;
         rresp_r  <= 1'b0;
      end else begin
         st_r     <= st_nxt;
         cls_r    <= cls_nxt;
         cmd_r    <= cmd_nxt;
         trk_r    <= trk_nxt;
         sec_r    <= sec_nxt;
         dat_r    <= dat_nxt;
         ctrl_r   <= ctrl_nxt;
         busy_r   <= busy_nxt;
         nrdy_r   <= nrdy_nxt;
         irq_r    <= irq_nxt;
         imm_r    <= imm_nxt;
         cond_r   <= cond_nxt;
         bcnt_r   <= bcnt_nxt;
         sync_r   <= sync_nxt;
         rdy_d_r  <= rdy_s;
         idx_d_r  <= idx_s;
         boot_r   <= 1'b0;
         bvalid_r <= bvalid_nxt;
         rvalid_r <= rvalid_nxt;
         rdata_r  <= rdata_nxt;
         bresp_r  <= bresp_nxt;
         rresp_r  <= rresp_nxt;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign completion_irq = irq_r;
   assign sep_sync_gate  = 1'b0;
   assign precomp_active = ctrl_r[`FCT_CTRL_PREC] && !ctrl_r[`FCT_CTRL_DENSEL];
   assign step_in        = 1'b0;
   assign s_axi_bvalid   = bvalid_r;
   assign s_axi_bresp    = {bresp_r, 1'b0};
   assign s_axi_rvalid   = rvalid_r;
   assign s_axi_rdata    = rdata_r;
   assign s_axi_rresp    = {rresp_r, 1'b0};
endmodule
`default_nettype wire

/* sim/fct_drive.sv */
`timescale 1ns/10ps
`default_nettype none
// drive model: ready and track-zero levels, stretched index pulse, byte stream
module fct_drive
   import fct_pkg::*;
(
   input  wire logic aclk,
   input  wire logic rdy,
   input  wire logic tz,
   input  wire logic idx_req,
   output var fct_drv_t drv,
   output logic [7:0] dbyte,
   output logic      mark
);
   logic [3:0] icnt   = 4'h0;  // index pulse width counter
   logic [7:0] cnt    = 8'h00; // byte pattern, moves every cycle
   logic       seen_r = 1'b0;  // index mark found once a pulse ends
   // index pulse lasts eight cycles so the synchroniser cannot miss it
   always @(posedge aclk) begin
      cnt <= cnt + 8'h01;
      if (idx_req) begin
         icnt <= 4'h8;
      end else if (icnt != 4'h0) begin
         icnt <= icnt - 4'h1;
      end
      if (icnt == 4'h1) begin
         seen_r <= 1'b1;
      end
   end
   assign drv   = {rdy, icnt != 4'h0, tz};
   assign dbyte = cnt;
   assign mark  = seen_r;
endmodule
`default_nettype wire

/* sim/fct_core_chk.sv */
`timescale 1ns/10ps
`default_nettype none
// watches the core's ports for interrupt and bus behaviour
module fct_core_chk
   import fct_pkg::*;
(
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   input  wire logic        s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic        s_axi_wvalid,
   input  wire logic        s_axi_wready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   input  wire logic        s_axi_arready,
   input  wire logic [31:0] s_axi_rdata,
   input  wire logic [1:0]  s_axi_rresp,
   input  wire logic        s_axi_rvalid,
   input  wire logic        completion_irq,
   input  wire logic        sep_sync_gate,
   input  wire logic        precomp_active
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // ----------------------------------------
   // helper logic
   // ----------------------------------------
   logic wr_any;     // write taken
   logic wr0;        // command write taken
   logic wrc;        // control write taken
   logic rd0;        // status read taken
   logic pc_want;    // precomp expected from write data
   logic clr_ok;     // access allowed to clear the interrupt
   logic sticky_r;   // immediate interrupt latched
   logic sticky_nxt;
   assign wr_any  = s_axi_awvalid & s_axi_awready & s_axi_wvalid & s_axi_wready;
   assign wr0     = wr_any & (s_axi_awaddr == 8'h00);
   assign wrc     = wr_any & (s_axi_awaddr == 8'h10);
   assign rd0     = s_axi_arvalid & s_axi_arready & (s_axi_araddr == 8'h00);
   assign pc_want = s_axi_wdata[1] & ~s_axi_wdata[0];
   assign clr_ok  = ((rd0 | wr0) & ~sticky_r) | (wr0 & (s_axi_wdata[7:0] == 8'hD0));
   // immediate condition latches, the all-zero force releases it
   always_comb begin
      sticky_nxt = sticky_r;
      if (wr0 && s_axi_wdata[7:4] == 4'hD) begin
         if (s_axi_wdata[3]) begin
            sticky_nxt = 1'b1;
         end else if (s_axi_wdata[3:0] == 4'h0) begin
            sticky_nxt = 1'b0;
         end
      end
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sticky_r <= 1'b0;
      end else begin
         sticky_r <= sticky_nxt;
      end
   end
   // ----------------------------------------
   // assertions
   // ----------------------------------------
   rst_irq_a: assert property (disable iff (1'b0) !aresetn |=> !completion_irq)
      else $error("interrupt high after reset");
   gate_off_a: assert property (!sep_sync_gate)
      else $error("sync gate active");
   irq_hold_a: assert property ($fell(completion_irq) |-> $past(clr_ok) || $past(clr_ok, 2))
      else $error("interrupt dropped without clearing access");
   zero_force_a: assert property (wr0 && s_axi_wdata[7:0] == 8'hD0 |-> ##2 (!completion_irq)[*3])
      else $error("interrupt after zero force");
   imm_irq_a: assert property (wr0 && s_axi_wdata[7:0] == 8'hD8 |-> ##[1:3] completion_irq)
      else $error("immediate force gave no interrupt");
   precomp_sel_a: assert property (wrc |-> ##2 precomp_active == $past(pc_want, 2))
      else $error("precomp enable wrong");
   bad_addr_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h10
      |=> s_axi_rvalid && s_axi_rresp == 2'b10)
      else $error("unmapped read not refused");
   upper_zero_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
      else $error("upper read bits set");
endmodule
bind fct_core fct_core_chk u_chk (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
   .s_axi_wdata, .s_axi_wvalid, .s_axi_wready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
   .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .completion_irq, .sep_sync_gate, .precomp_active);
`default_nettype wire

/* sim/tb_floppy_cmd_termination_irq.sv */
`timescale 1ns/10ps
`default_nettype none
module tb_floppy_cmd_termination_irq
   import fct_pkg::*;
;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'h1;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   fct_drv_t drv_in;
   logic [7:0] disk_byte;
   logic index_mark_seen, completion_irq, sep_sync_gate, precomp_active, step_in;
   logic rdy = 1'b0, tz = 1'b0, idx = 1'b0;  // drive model controls
   int err_count = 0;
   int total_checks = 0;
   logic [31:0] seed = 32'h00000033;
   logic [31:0] v, rv;
   logic [1:0] rr;
   logic [7:0] codes [4] = '{8'hD4, 8'hD2, 8'hD1, 8'hD6};

   always #2 aclk = ~aclk;

   fct_core uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready, .drv_in, .disk_byte, .index_mark_seen, .completion_irq, .sep_sync_gate,
      .precomp_active, .step_in);
   fct_drive u_drv (.aclk, .rdy, .tz, .idx_req(idx), .drv(drv_in), .dbyte(disk_byte),
      .mark(index_mark_seen));

   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         $display("wrong value at %0t seen %h exp %h", $time, seen, exp);
         err_count++;
      end
   endtask

   task automatic results();
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // bus write: address and data offered together, held until taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic ta, tw, tb;
      int n;
      n = 0;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(negedge aclk);
         ta = s_axi_awvalid & (s_axi_awready === 1'b1);
         tw = s_axi_wvalid & (s_axi_wready === 1'b1);
         tb = s_axi_bready & (s_axi_bvalid === 1'b1);
         @(posedge aclk);
         if (ta) s_axi_awvalid <= 1'b0;
         if (tw) s_axi_wvalid <= 1'b0;
         if (tb) s_axi_bready <= 1'b0;
         n++;
      end while (!tb && n < 300);
      if (!tb) err_count++;
   endtask

   // bus read: address held until taken, data captured with rvalid
   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      logic ta, t;
      int n;
      n = 0;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(negedge aclk);
         ta = s_axi_arvalid & (s_axi_arready === 1'b1);
         t = s_axi_rready & (s_axi_rvalid === 1'b1);
         d = s_axi_rdata;
         r = s_axi_rresp;
         @(posedge aclk);
         if (ta) s_axi_arvalid <= 1'b0;
         if (t) s_axi_rready <= 1'b0;
         n++;
      end while (!t && n < 300);
      if (!t) err_count++;
   endtask

   // wait a bounded time for the interrupt, then compare it
   task automatic wirq(input int lim);
      int n;
      n = 0;
      do @(negedge aclk); while (completion_irq !== 1'b1 && ++n < lim);
      chk({31'h0, completion_irq}, 32'h1);
   endtask

   task automatic ck_irq(input logic e);
      @(negedge aclk);
      chk({31'h0, completion_irq}, {31'h0, e});
   endtask

   // watchdog: far beyond the longest expected run
   initial begin
      repeat (60000) @(posedge aclk);
      err_count++;
      results();
   end

   initial begin
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (5) @(posedge aclk);
      rd(8'h00, rv, rr);
      chk(rv & 32'h81, 32'h81);
      rd(8'h08, rv, rr);
      chk(rv, 32'h01);
      tz <= 1'b1;
      chk({31'h0, step_in}, 32'h0);
      wirq(9000);
      rd(8'h00, rv, rr);
      chk(rv & 32'h81, 32'h80);
      ck_irq(1'b0);
      $display("test restore end");
      // type II refused while not ready
      wr(8'h00, 32'h80);
      wirq(20);
      rd(8'h00, rv, rr);
      chk(rv & 32'h81, 32'h80);
      ck_irq(1'b0);
      $display("test not ready end");
      // id read lasts six byte times
      rdy <= 1'b1;
      repeat (10) @(posedge aclk);
      wr(8'h00, 32'hC0);
      repeat (5) begin
         repeat (990) @(posedge aclk);
         rd(8'h0C, rv, rr);
         chk({30'h0, rr}, 32'h0);
      end
      ck_irq(1'b0);
      wirq(2000);
      rd(8'h00, rv, rr);
      chk(rv & 32'h81, 32'h00);
      $display("test id read end");
      // zero force ends a running command quietly
      wr(8'h00, 32'hC0);
      repeat (50) @(posedge aclk);
      wr(8'h00, 32'hD0);
      rd(8'h00, rv, rr);
      chk(rv & 32'h01, 32'h00);
      repeat (7000) @(posedge aclk);
      ck_irq(1'b0);
      // immediate force survives status read, zero force then clears it
      wr(8'h00, 32'hD8);
      ck_irq(1'b1);
      rd(8'h00, rv, rr);
      ck_irq(1'b1);
      wr(8'h00, 32'hD0);
      repeat (2) @(posedge aclk);
      ck_irq(1'b0);
      $display("test force end");
      // track read locks on the first index mark and ends at the next index
      wr(8'h00, 32'hE0);
      idx <= 1'b1;
      @(posedge aclk);
      idx <= 1'b0;
      repeat (1100) @(posedge aclk);
      ck_irq(1'b0);
      @(posedge aclk);
      idx <= 1'b1;
      @(posedge aclk);
      idx <= 1'b0;
      wirq(60);
      rd(8'h00, rv, rr);
      chk(rv & 32'h01, 32'h00);
      $display("test track read end");
      // conditional forces: index, ready fall, ready rise, two ORed
      for (int i = 0; i < 4; i++) begin
         wr(8'h00, {24'h0, codes[i]});
         ck_irq(1'b0);
         @(posedge aclk);
         if (codes[i][2]) idx <= 1'b1;
         else rdy <= ~rdy;
         @(posedge aclk);
         idx <= 1'b0;
         wirq(60);
         rd(8'h00, rv, rr);
         ck_irq(1'b0);
      end
      $display("test conditions end");
      // density and precomp control, all four corners then random
      for (int i = 0; i < 8; i++) begin
         v = (i < 4) ? i : xs();
         wr(8'h10, {30'h0, v[1:0]});
         repeat (2) @(posedge aclk);
         @(negedge aclk);
         chk({31'h0, precomp_active}, {31'h0, v[1] & ~v[0]});
      end
      // track and sector registers, then an unmapped place
      for (int i = 0; i < 4; i++) begin
         v = xs() & 32'hFF;
         wr((i % 2) ? 8'h08 : 8'h04, v);
         rd((i % 2) ? 8'h08 : 8'h04, rv, rr);
         chk(rv, v);
      end
      rd(8'h14, rv, rr);
      chk({30'h0, rr}, 32'h2);
      chk(rv, 32'h0);
      $display("test registers end");
      results();
   end
endmodule
`default_nettype wire
